// *** dv/switch_config_decoder_test.sv ***
// Self-checking bench for the switch setting decoder
`timescale 1ns/100ps
module switch_config_decoder_test
  import switch_config_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [1:0]  rate;
  wire  [3:0]  tens;
  wire  [3:0]  units;
  wire  [3:0]  div;
  wire         gate;
  wire         a_in;
  wire  [1:0]  net_rate_code;
  wire  [7:0]  node_address;
  wire         net_enable;
  wire         config_fault;
  wire         config_done;
  wire         divided_pulse_out;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          n_toggle = 0;
  int          cycles = 0;

  switch_config_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rate_select_switch(rate), .node_id_tens_switch(tens),
    .node_id_units_switch(units), .pulse_divider_switch(div),
    .encoder_gate_switch(gate), .encoder_a_in(a_in),
    .net_rate_code(net_rate_code), .node_address(node_address),
    .net_enable(net_enable), .config_fault(config_fault),
    .config_done(config_done), .divided_pulse_out(divided_pulse_out));

  switch_panel_model panel (.pclk(pclk), .rate_select_switch(rate),
    .node_id_tens_switch(tens), .node_id_units_switch(units),
    .pulse_divider_switch(div), .encoder_gate_switch(gate),
    .encoder_a_in(a_in));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(divided_pulse_out) n_toggle++;

  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // Samples pready before the edge's own updates land
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    check(32'(n), 32'h2, "answer delay");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (39) @(posedge pclk);
    check(32'(config_done), 32'h0, "done early");
    repeat (2) @(posedge pclk);
    check(32'(config_done), 32'h1, "done late");
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_defaults;
    do_reset();
    check(32'(net_rate_code), 32'h2, "default rate");
    check(32'(node_address), 32'h3f, "default node");
    check(32'(net_enable), 32'h1, "default online");
    check(32'(config_fault), 32'h0, "default fault");
  endtask

  task automatic t_rates;
    logic [31:0] rd;
    logic        er;
    for (int c = 0; c < 4; c++) begin
      panel.set(2'(c), 4'h6, 4'h3, 4'h3, 1'b1);
      do_reset();
      check(32'(net_rate_code), 32'(c), "rate");
      check(32'(config_fault), 32'(c == 3), "rate fault");
      check(32'(net_enable), 32'(c != 3), "rate online");
      panel.set(2'(c ^ 1), 4'h6, 4'h3, 4'h3, 1'b1);
      repeat (10) @(posedge pclk);
      check(32'(net_rate_code), 32'(c), "rate moved");
      apb(1'b0, 8'h00, 32'h0, rd, er);
      check(rd[2:0], {29'h0, c == 3, 2'(c)}, "status rate");
    end
  endtask

  task automatic t_node;
    logic [3:0] tn [6] = '{4'h4, 4'h0, 4'h7, 4'h0, 4'h6, 4'h0};
    logic [3:0] un [6] = '{4'h2, 4'h0, 4'h0, 4'h1, 4'h4, 4'hc};
    logic [7:0] ex;
    logic       f;
    panel.set(2'h2, 4'h6, 4'h3, 4'h3, 1'b1);
    do_reset();
    for (int i = 0; i < 6; i++) begin
      ex = tn[i] * 8'ha + un[i];
      f = ex == 8'h0 || ex > 8'h3f || un[i] > 4'h9;
      panel.set(2'h1, tn[i], un[i], 4'h3, 1'b1);
      repeat (8) @(posedge pclk);
      check(32'(node_address), 32'(ex), "node");
      check(32'(config_fault), 32'(f), "node fault");
      check(32'(net_enable), 32'(!f), "node online");
    end
  endtask

  task automatic t_pulses;
    logic [3:0]  dv [4] = '{4'h3, 4'h1, 4'h5, 4'h1};
    logic        gt [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    int          tg [4] = '{4, 8, 4, 0};
    logic [31:0] c0;
    logic [31:0] c1;
    logic        er;
    for (int i = 0; i < 4; i++) begin
      panel.set(2'h2, 4'h6, 4'h3, dv[i], gt[i]);
      repeat (8) @(posedge pclk);
      apb(1'b0, 8'h08, 32'h0, c0, er);
      n_toggle = 0;
      panel.pulses(8);
      repeat (12) @(posedge pclk);
      check(32'(n_toggle), 32'(tg[i]), "toggles");
      apb(1'b0, 8'h08, 32'h0, c1, er);
      check(32'(c1[15:0] - c0[15:0]), gt[i] ? 32'h8 : 32'h0, "count");
    end
  endtask

  task automatic t_apb;
    logic [31:0] rd;
    logic        er;
    panel.set(2'h2, 4'h6, 4'h3, 4'h3, 1'b1);
    repeat (8) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0, rd, er);
    check(rd, 32'h1, "control reset");
    apb(1'b1, 8'h04, 32'h0, rd, er);
    repeat (2) @(posedge pclk);
    check(32'(net_enable), 32'h0, "request off");
    apb(1'b1, 8'h04, 32'h1, rd, er);
    repeat (2) @(posedge pclk);
    check(32'(net_enable), 32'h1, "request on");
    apb(1'b0, 8'h0c, 32'h0, rd, er);
    check({rd[30:0], er}, 32'h1, "unmapped");
    apb(1'b0, 8'h00, 32'h0, rd, er);
    check(rd[15:4], 12'h3ff, "status");
  endtask

  // -----------------------------------------------------------------
  // Sequence and hang guard
  // -----------------------------------------------------------------
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("[FAIL] %0t timeout", $time);
      complete_run();
    end
  end

  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h0;
    pwdata  = 32'h0;
    t_defaults();
    t_rates();
    t_node();
    t_pulses();
    t_apb();
    complete_run();
  end
endmodule

// *** dv/switch_panel_model.sv ***
// Partner model: board setting switches and encoder A-phase source
`timescale 1ns/100ps
module switch_panel_model (
  input  wire logic       pclk,
  output logic      [1:0] rate_select_switch,
  output logic      [3:0] node_id_tens_switch,
  output logic      [3:0] node_id_units_switch,
  output logic      [3:0] pulse_divider_switch,
  output logic            encoder_gate_switch,
  output logic            encoder_a_in
);
  // -----------------------------------------------------------------
  // Factory positions at power-up
  // -----------------------------------------------------------------
  initial begin
    rate_select_switch   = 2'h2;
    node_id_tens_switch  = 4'h6;
    node_id_units_switch = 4'h3;
    pulse_divider_switch = 4'h3;
    encoder_gate_switch  = 1'b1;
    encoder_a_in         = 1'b0;
  end

  // Operator moves switches; bad addresses only when a test asks
  task automatic set(input logic [1:0] r, input logic [3:0] t,
                     input logic [3:0] u, input logic [3:0] d,
                     input logic g);
    @(posedge pclk);
    rate_select_switch   <= r;
    node_id_tens_switch  <= t;
    node_id_units_switch <= u;
    pulse_divider_switch <= d;
    encoder_gate_switch  <= g;
  endtask

  // Each level held 4 cycles, well above the 2-cycle filter
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      encoder_a_in <= 1'b1;
      repeat (4) @(posedge pclk);
      encoder_a_in <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
endmodule

// *** logic/pulse_divider.sv ***
// Divides gated A-phase edges by two or by four
`timescale 1ns/100ps
module pulse_divider
  import switch_config_pkg::*;
(
  input  wire logic    pclk,
  input  wire logic    presetn,
  pulse_link_if.div    link
);

  typedef struct packed {
    logic half_seen;
    logic out;
  } div_state_type;

  div_state_type r;
  div_state_type r_next;

  always_comb begin
    r_next = r;
    if (link.pulse_edge) begin
      if (!link.quarter || r.half_seen) begin
        r_next.out       = ~r.out;
        r_next.half_seen = 1'b0;
      end else begin
        r_next.half_seen = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= r_next;
    end
  end

  assign link.divided = r.out;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  half_ratio_a: assert property ( // R10
    @(posedge pclk) disable iff (!presetn)
    (link.pulse_edge && !link.quarter) |=> (r.out != $past(r.out)))
    else $error("half ratio did not toggle on every edge");

  quarter_ratio_a: assert property ( // R9
    @(posedge pclk) disable iff (!presetn)
    (link.pulse_edge && link.quarter) |=>
      ((r.out != $past(r.out)) == $past(r.half_seen)))
    else $error("quarter ratio toggled on wrong edge");

  no_edge_hold_a: assert property ( // R12
    @(posedge pclk) disable iff (!presetn)
    !link.pulse_edge |=> $stable(r.out))
    else $error("divided output moved without an edge");

endmodule

// *** logic/pulse_link_if.sv ***
// Carrier between the decoder and the pulse divider
`timescale 1ns/100ps
interface pulse_link_if;
  logic pulse_edge;
  logic quarter;
  logic divided;

  modport src (output pulse_edge, output quarter, input divided);
  modport div (input pulse_edge, input quarter, output divided);
endinterface

// *** logic/switch_config_decoder.sv ***
// Setting switch decoder: network rate, node address, pulse path
//
// Behaviour
// R1 - Rate captured at power-up only
// R2 - Rate bits decode 125k, 250k, 500k, prohibited
// R3 - Rate default gives 500 kbit/s
// R4 - Node address from tens and units digits
// R5 - Operator keeps node address within 1..63
// R6 - Node address default is 63
// R7 - Gate switch off blocks encoder pulses
// R8 - Gate switch default is on
// R9 - Divider position 3 gives quarter frequency
// R10 - Divider position 1 gives half frequency
// R11 - Divider default position is 3
// R12 - Divided output derives from A-phase only
// R13 - Bad rate or address: offline, fault raised
// R14 - Other divider positions behave as quarter
`timescale 1ns/100ps
`include "switch_config_params.svh"
module switch_config_decoder
  import switch_config_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output wire logic [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  input  wire logic [1:0]  rate_select_switch,
  input  wire logic [3:0]  node_id_tens_switch,
  input  wire logic [3:0]  node_id_units_switch,
  input  wire logic [3:0]  pulse_divider_switch,
  input  wire logic        encoder_gate_switch,
  input  wire logic        encoder_a_in,
  output wire logic [1:0]  net_rate_code,
  output wire logic [7:0]  node_address,
  output wire logic        net_enable,
  output wire logic        config_fault,
  output wire logic        config_done,
  output wire logic        divided_pulse_out
);

  localparam int PIN_W = 16;
  localparam int SETTLE_W = 6;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST =
    SETTLE_W'(`SETTLE_CYCLES - 1);

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    phase_type          phase;
    logic [SETTLE_W-1:0] settle;
    logic [PIN_W-1:0]   s1;
    logic [PIN_W-1:0]   s2;
    logic [PIN_W-1:0]   s3;
    logic [PIN_W-1:0]   pins;
    logic               a_prev;
    logic               edge_p;
    logic [1:0]         rate;
    logic               rate_bad;
    logic [7:0]         node;
    logic               addr_bad;
    logic               fault;
    logic               online;
    logic               net_req;
    logic               quarter;
    logic               pulse_out;
    logic [15:0]        pcount;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } state_type;

  // Switch defaults reach the pin stages at reset
  localparam logic [PIN_W-1:0] PIN_RESET = {
    1'b0, `GATE_DEFAULT, `DIV_DEFAULT, // R8 R11
    `UNITS_DEFAULT, `TENS_DEFAULT,     // R6
    `RATE_DEFAULT                      // R3
  };

  localparam state_type RESET_STATE = '{
    phase:     PHASE_INIT,
    settle:    '0,
    s1:        PIN_RESET,
    s2:        PIN_RESET,
    s3:        PIN_RESET,
    pins:      PIN_RESET,
    a_prev:    1'b0,
    edge_p:    1'b0,
    rate:      `RATE_DEFAULT,
    rate_bad:  1'b0,
    node:      8'h3f,
    addr_bad:  1'b0,
    fault:     1'b0,
    online:    1'b0,
    net_req:   `CONTROL_RESET,
    quarter:   1'b1,
    pulse_out: 1'b0,
    pcount:    16'h0000,
    pready:    1'b0,
    pslverr:   1'b0,
    prdata:    32'h0000_0000
  };

  state_type r;
  state_type r_next;

  pulse_link_if link ();

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic digit_ok(input logic [3:0] d);
    digit_ok = (d <= `DIGIT_MAX);
  endfunction

  function automatic logic [7:0] digit_wide(input logic [3:0] d);
    digit_wide = {4'h0, d};
  endfunction

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_agree;
  logic [3:0]       tens;
  logic [3:0]       units;
  logic [3:0]       div_pos;
  logic             gate;
  logic [7:0]       node_val;
  logic             node_bad;
  logic             apb_go;

  assign pin_raw = {encoder_a_in, encoder_gate_switch,
                    pulse_divider_switch, node_id_units_switch,
                    node_id_tens_switch, rate_select_switch};

  always_comb begin
    r_next = r;

    // Three-stage pin sampling; a bit moves once stages two and
    // three agree, which filters a single-cycle glitch.
    r_next.s1 = pin_raw;
    r_next.s2 = r.s1;
    r_next.s3 = r.s2;
    pin_agree = ~(r.s2 ^ r.s3);
    r_next.pins = (r.s3 & pin_agree) | (r.pins & ~pin_agree);

    tens    = r.pins[`PIN_TENS_LSB +: 4];
    units   = r.pins[`PIN_UNITS_LSB +: 4];
    div_pos = r.pins[`PIN_DIV_LSB +: 4];
    gate    = r.pins[`PIN_GATE_BIT];

    // Address recomputed live; a digit above nine is never valid
    node_val = 8'(digit_wide(tens) * 8'd10) + digit_wide(units); // R4
    node_bad = !digit_ok(tens) || !digit_ok(units) ||
               (node_val < `NODE_MIN) || (node_val > `NODE_MAX);
    r_next.node     = node_val;
    r_next.addr_bad = node_bad;                                 // R13

    // Rate taken once after the pins have settled
    case (r.phase)
      PHASE_INIT: begin
        r_next.settle = r.settle + SETTLE_W'(1);
        if (r.settle == SETTLE_LAST) begin
          r_next.phase    = PHASE_RUN;
          r_next.rate     = r.pins[`PIN_RATE_LSB +: 2];         // R1
          r_next.rate_bad =
            (r.pins[`PIN_RATE_LSB +: 2] == RATE_NONE);          // R2
        end
      end
      PHASE_RUN: begin
        r_next.settle = r.settle;
      end
      default: begin
        r_next.phase = PHASE_INIT;
      end
    endcase

    r_next.fault  = r_next.rate_bad || node_bad;                // R13
    r_next.online = (r_next.phase == PHASE_RUN) && r.net_req &&
                    !r_next.fault;                              // R13

    // Only the A-phase edge drives the divider
    r_next.a_prev = r.pins[`PIN_A_BIT];
    r_next.edge_p = gate && r.pins[`PIN_A_BIT] && !r.a_prev;  // R7 R12
    if (r.edge_p) begin
      r_next.pcount = r.pcount + 16'h0001;
    end

    // Unsupported positions fall back to quarter
    r_next.quarter = (div_pos != `DIV_HALF_POS);          // R9 R10 R14
    r_next.pulse_out = link.divided;

    // APB slave: one wait state, answer in the second access cycle
    apb_go = psel && penable && !r.pready;
    r_next.pready  = apb_go;
    r_next.pslverr = 1'b0;
    r_next.prdata  = 32'h0000_0000;
    if (apb_go) begin
      case (paddr)
        `STATUS_OFFSET: begin
          r_next.prdata[`ST_RATE_LSB +: 2]  = r.rate;
          r_next.prdata[`ST_RATE_BAD_BIT]   = r.rate_bad;
          r_next.prdata[`ST_ADDR_BAD_BIT]   = r.addr_bad;
          r_next.prdata[`ST_ONLINE_BIT]     = r.online;
          r_next.prdata[`ST_GATE_BIT]       = gate;
          r_next.prdata[`ST_QUARTER_BIT]    = r.quarter;
          r_next.prdata[`ST_RUN_BIT]        = (r.phase == PHASE_RUN);
          r_next.prdata[`ST_NODE_LSB +: 8]  = r.node;
        end
        `CONTROL_OFFSET: begin
          r_next.prdata[`CT_NET_REQ_BIT] = r.net_req;
        end
        `PULSE_COUNT_OFFSET: begin
          r_next.prdata[15:0] = r.pcount;
        end
        default: begin
          r_next.pslverr = 1'b1;
        end
      endcase
    end

    // Write lands on the edge at which the master sees pready
    if (psel && penable && r.pready && pwrite &&
        (paddr == `CONTROL_OFFSET)) begin
      r_next.net_req = pwdata[`CT_NET_REQ_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= RESET_STATE;
    end else begin
      r <= r_next;
    end
  end

  // -----------------------------------------------------------------
  // Divider and outputs
  // -----------------------------------------------------------------
  assign link.pulse_edge = r.edge_p;
  assign link.quarter    = r.quarter;

  pulse_divider u_divider (
    .pclk    (pclk),
    .presetn (presetn),
    .link    (link)
  );

  assign prdata            = r.prdata;
  assign pready            = r.pready;
  assign pslverr           = r.pslverr;
  assign net_rate_code     = r.rate;
  assign node_address      = r.node;
  assign net_enable        = r.online;
  assign config_fault      = r.fault;
  assign config_done       = r.phase; // Run phase is code 1
  assign divided_pulse_out = r.pulse_out;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  rate_hold_a: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    (r.phase == PHASE_RUN) |=> ($stable(r.rate) && $stable(r.rate_bad)))
    else $error("rate changed after capture");

  rate_decode_a: assert property ( // R2
    @(posedge pclk) disable iff (!presetn)
    (r.phase == PHASE_RUN) |-> (r.rate_bad == (r.rate == RATE_NONE)))
    else $error("prohibited rate not flagged");

  node_form_a: assert property ( // R4
    @(posedge pclk) disable iff (!presetn)
    ##1 (r.node == 8'(digit_wide($past(r.pins[`PIN_TENS_LSB +: 4]))
      * 8'd10) + digit_wide($past(r.pins[`PIN_UNITS_LSB +: 4]))))
    else $error("node address not tens times ten plus units");

  node_range_a: assert property ( // R13
    @(posedge pclk) disable iff (!presetn)
    ((r.node < `NODE_MIN) || (r.node > `NODE_MAX)) |-> r.fault)
    else $error("out of range address without fault");

  fault_offline_a: assert property ( // R13
    @(posedge pclk) disable iff (!presetn)
    r.fault |-> !r.online)
    else $error("online while configuration faulty");

  gate_block_a: assert property ( // R7
    @(posedge pclk) disable iff (!presetn)
    !r.pins[`PIN_GATE_BIT] |=> !r.edge_p)
    else $error("pulse passed with gate off");

  ratio_select_a: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    (r.pins[`PIN_DIV_LSB +: 4] != `DIV_HALF_POS) |=> r.quarter)
    else $error("unsupported position not quarter");

  apb_answer_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !r.pready) |=> (r.pready ##1 !r.pready))
    else $error("apb answer not a single cycle");

  fault_source_a: assert property ( // R13
    @(posedge pclk) disable iff (!presetn)
    r.fault == (r.rate_bad || r.addr_bad))
    else $error("fault flag not from rate or address");

  online_need_a: assert property ( // R13
    @(posedge pclk) disable iff (!presetn)
    r.online |-> ((r.phase == PHASE_RUN) && !r.rate_bad && !r.addr_bad))
    else $error("online before capture or with a fault");

  phase_rise_a: assert property ( // R7 R12
    @(posedge pclk) disable iff (!presetn)
    r.edge_p |-> ($past(r.pins[`PIN_A_BIT]) && !$past(r.a_prev) &&
                  $past(r.pins[`PIN_GATE_BIT])))
    else $error("edge pulse without a gated A-phase rise");

  half_select_a: assert property ( // R10
    @(posedge pclk) disable iff (!presetn)
    (r.pins[`PIN_DIV_LSB +: 4] == `DIV_HALF_POS) |=> !r.quarter)
    else $error("position one did not select half");

  rate_capture_a: assert property ( // R1
    @(posedge pclk) disable iff (!presetn)
    ((r.phase == PHASE_INIT) && (r.settle == SETTLE_LAST)) |=>
      ((r.phase == PHASE_RUN) &&
       (r.rate == $past(r.pins[`PIN_RATE_LSB +: 2]))))
    else $error("rate not taken at end of settling");

  slverr_pair_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    r.pslverr |-> r.pready)
    else $error("error response outside an answer cycle");

  read_idle_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !r.pready |-> (r.prdata == 32'h0000_0000))
    else $error("read data not zero outside answer");

  control_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && r.pready && pwrite &&
     (paddr == `CONTROL_OFFSET)) |=>
      (r.net_req == $past(pwdata[`CT_NET_REQ_BIT])))
    else $error("control write did not land at the answer edge");

endmodule

// *** logic/switch_config_params.svh ***
// Offsets, field positions, reset values and timing counts
`ifndef SWITCH_CONFIG_PARAMS_SVH
`define SWITCH_CONFIG_PARAMS_SVH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define STATUS_OFFSET      8'h00
`define CONTROL_OFFSET     8'h04
`define PULSE_COUNT_OFFSET 8'h08

// -----------------------------------------------------------------
// Status register fields
// -----------------------------------------------------------------
`define ST_RATE_LSB        0
`define ST_RATE_BAD_BIT    2
`define ST_ADDR_BAD_BIT    3
`define ST_ONLINE_BIT      4
`define ST_GATE_BIT        5
`define ST_QUARTER_BIT     6
`define ST_RUN_BIT         7
`define ST_NODE_LSB        8

// -----------------------------------------------------------------
// Control register fields and reset value
// -----------------------------------------------------------------
`define CT_NET_REQ_BIT     0
`define CONTROL_RESET      1'b1

// -----------------------------------------------------------------
// Pin vector layout
// -----------------------------------------------------------------
`define PIN_RATE_LSB       0
`define PIN_TENS_LSB       2
`define PIN_UNITS_LSB      6
`define PIN_DIV_LSB        10
`define PIN_GATE_BIT       14
`define PIN_A_BIT          15

// -----------------------------------------------------------------
// Switch defaults and decode values
// -----------------------------------------------------------------
`define RATE_DEFAULT       2'h2
`define TENS_DEFAULT       4'h6
`define UNITS_DEFAULT      4'h3
`define DIV_DEFAULT        4'h3
`define GATE_DEFAULT       1'b1
`define DIV_HALF_POS       4'h1
`define NODE_MIN           8'h01
`define NODE_MAX           8'h3f
`define DIGIT_MAX          4'h9

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define CLK_PERIOD_NS      25
`define SETTLE_NS          1000
`define SETTLE_CYCLES \
  ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** logic/switch_config_pkg.sv ***
// Types shared by the switch decoder and its pulse divider
package switch_config_pkg;

  typedef enum logic [1:0] {
    RATE_125K  = 2'b00,
    RATE_250K  = 2'b01,
    RATE_500K  = 2'b10,
    RATE_NONE  = 2'b11
  } rate_type;

  typedef enum logic {
    PHASE_INIT = 1'b0,
    PHASE_RUN  = 1'b1
  } phase_type;

endpackage
